/* File: smec_overflow_check.sv */
// Lost digit check that decides between alarm and silent truncation
`timescale 1ns/100ps
`default_nettype none
module smec_overflow_check
	import smec_pkg::*;
(
	// Finished instruction
	input wire logic [3:0] op,
	input wire logic [3:0] leadDigit,
	input wire logic lowLost,
	// Verdict
	output logic alarm,
	output logic truncEvent
);

	always_comb begin
		alarm = 1'b0;
		truncEvent = 1'b0;
		case (op)
			OP_ADD, OP_SUB: begin
				alarm = (leadDigit != 4'h0);
			end
			OP_DIV: begin
				alarm = (leadDigit != 4'h0);
			end
			OP_MUL: begin
				truncEvent = lowLost;
			end
			default: begin
				alarm = 1'b0;
			end
		endcase
	end

endmodule // smec_overflow_check
`default_nettype wire

/* File: smec_panel.sv */
// Operator panel model: buttons, toggles and dials
`timescale 1ns/100ps
`default_nettype none
module smec_panel
	import smec_pkg::*;
(
	// Clock and lamp
	input wire logic core_clk,
	input wire logic haltLamp,
	// Controls
	output logic stepStartButton,
	output logic clearButton,
	output logic singleStepSwitch,
	output logic manualSourceSwitch,
	output smec_instr_t dials
);
	initial begin
		stepStartButton = 1'b0;
		clearButton = 1'b0;
		singleStepSwitch = 1'b0;
		manualSourceSwitch = 1'b0;
		dials = '0;
	end
	// One press of start or clear
	task automatic hit(input logic clr);
		@(posedge core_clk);
		clearButton <= clr;
		stepStartButton <= !clr;
		@(posedge core_clk);
		clearButton <= 1'b0;
		stepStartButton <= 1'b0;
	endtask
	// Manual source only once stopped in single mode
	task automatic setSw(input logic single, input logic manual);
		@(posedge core_clk);
		singleStepSwitch <= single;
		manualSourceSwitch <= manual && single && haltLamp === 1'b1;
	endtask
	task automatic setDials(input smec_instr_t d);
		@(posedge core_clk);
		dials <= d;
	endtask
endmodule // smec_panel
`default_nettype wire

/* File: smec_pkg.sv */
// Shared constants and types for the step and manual execution sequencer
package smec_pkg;

	// Instruction fields and program position
	localparam int FIELD_W = 4;
	localparam int POS_W = 7;
	localparam logic [6:0] POS_RESET = 7'h00;

	// Operation codes carried in the first field
	localparam logic [3:0] OP_ADD = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_MUL = 4'h3;
	localparam logic [3:0] OP_DIV = 4'h4;
	localparam logic [3:0] OP_SHIFT = 4'h5;
	localparam logic [3:0] OP_STORE = 4'h6;
	localparam logic [3:0] OP_PRINT = 4'h7;

	// Motor bar selection
	localparam int BAR_N = 4;
	localparam logic [3:0] BAR_FIRST = 4'h1;
	localparam logic [3:0] BAR_LAST = 4'h4;
	localparam logic [3:0] UNIT_NOPRINT = 4'h0;

	// Register byte offsets
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_IRQ_STAT = 4'h4;
	localparam logic [3:0] REG_IRQ_MASK = 4'h8;
	localparam logic [3:0] REG_CTRL = 4'hC;

	// Status register fields
	localparam int STAT_POS_LSB = 0;
	localparam int STAT_HALT_BIT = 8;
	localparam int STAT_ALARM_BIT = 9;
	localparam int STAT_RUN_BIT = 10;
	localparam int STAT_SINGLE_BIT = 11;
	localparam int STAT_MANUAL_BIT = 12;

	// Event bits, shared by status and mask
	localparam int IRQ_W = 4;
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_STEP = 1;
	localparam int IRQ_MANUAL = 2;
	localparam int IRQ_TRUNC = 3;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// Control register fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;

	typedef struct packed {
		logic [3:0] op;
		logic [3:0] addr;
		logic [3:0] unit;
	} smec_instr_t;

	typedef struct packed {
		logic done;
		logic jump;
		logic [6:0] target;
		logic [3:0] leadDigit;
		logic lowLost;
	} smec_result_t;

	typedef enum {ST_HALT, ST_FETCH, ST_EXEC, ST_ALARM} smec_state_t;

	// Number of fields an operation really uses
	function automatic logic [1:0] smec_field_count(input logic [3:0] op);
		case (op)
			OP_STORE: smec_field_count = 2'h1;
			OP_SHIFT: smec_field_count = 2'h2;
			default: smec_field_count = 2'h3;
		endcase
	endfunction

endpackage

/* File: smec_sequencer.sv */
// Execution sequencer: continuous, single-step and manual dial execution
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module smec_sequencer
	import smec_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [3:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	output logic irq,
	// Operator panel
	input wire logic stepStartButton,
	input wire logic clearButton,
	input wire logic singleStepSwitch,
	input wire logic manualSourceSwitch,
	input wire logic [3:0] dialOp,
	input wire logic [3:0] dialAddr,
	input wire logic [3:0] dialUnit,
	// Lamps
	output logic haltLamp,
	output logic alarmLamp,
	output logic [6:0] progPos,
	// Stored program
	input wire smec_instr_t progInstr,
	// Execution unit
	output logic execStart,
	output smec_instr_t execInstr,
	output logic execManual,
	input wire smec_result_t execResult,
	// Printer carriage
	output logic printEnable,
	output logic [3:0] motorBar
);

	// Sequencer state
	smec_state_t state;
	smec_state_t next_state;
	logic [6:0] pos;
	logic [6:0] next_pos;
	logic singleLatched;
	logic next_singleLatched;
	logic manualLatched;
	logic next_manualLatched;
	logic prevStart;
	smec_instr_t instr;
	smec_instr_t next_instr;
	logic startPulse;
	logic next_startPulse;
	logic printEn;
	logic next_printEn;
	logic [3:0] bar;
	logic [3:0] next_bar;

	// Bus and event state
	logic ack;
	logic next_ack;
	logic [31:0] rdData;
	logic [31:0] next_rdData;
	logic [3:0] irqStat;
	logic [3:0] next_irqStat;
	logic [3:0] irqMask;
	logic [3:0] next_irqMask;

	// Lamp and interrupt state
	logic haltShown;
	logic next_haltShown;
	logic alarmShown;
	logic next_alarmShown;
	logic irqLevel;
	logic next_irqLevel;

	// Combinational helpers
	logic startPress;
	logic softStart;
	logic softClear;
	logic clearReq;
	logic busWrite;
	logic execAlarm;
	logic execTrunc;
	logic [3:0] events;
	logic [3:0] w1c;
	smec_instr_t dialInstr;
	smec_instr_t fetched;
	logic [3:0] barHit;

	// Overflow verdict for the finished instruction
	smec_overflow_check overflowCheck (
		.op(instr.op),
		.leadDigit(execResult.leadDigit),
		.lowLost(execResult.lowLost),
		.alarm(execAlarm),
		.truncEvent(execTrunc)
	);

	// Blank the fields an operation does not use
	function automatic smec_instr_t mask_fields(input smec_instr_t in);
		logic [1:0] used;
		mask_fields = in;
		used = smec_field_count(in.op);
		if (used < 2'h3) begin
			mask_fields.unit = 4'h0;
		end
		if (used < 2'h2) begin
			mask_fields.addr = 4'h0;
		end
	endfunction

	// One comparator per motor bar
	for (genvar b = 0; b < BAR_N; b++) begin : gBar
		assign barHit[b] = (next_instr.addr == BAR_FIRST + 4'(b));
	end

	// Bus decode
	assign busWrite = avsWrite && ack;
	assign softStart = busWrite && (avsAddress == REG_CTRL) && avsByteEnable[0]
		&& avsWriteData[CTRL_START_BIT];
	assign softClear = busWrite && (avsAddress == REG_CTRL) && avsByteEnable[0]
		&& avsWriteData[CTRL_CLEAR_BIT];
	assign clearReq = clearButton || softClear;
	assign startPress = (stepStartButton && !prevStart) || softStart;

	// Instructions from dials and from the program store
	always_comb begin
		dialInstr.op = dialOp;
		dialInstr.addr = dialAddr;
		dialInstr.unit = dialUnit;
		dialInstr = mask_fields(dialInstr);
		fetched = mask_fields(progInstr);
	end

	// Sequencer next state
	always_comb begin
		next_state = state;
		next_pos = pos;
		next_singleLatched = singleLatched;
		next_manualLatched = manualLatched;
		next_instr = instr;
		next_startPulse = 1'b0;
		next_printEn = 1'b0;
		next_bar = bar;
		events = 4'h0;
		case (state)
			ST_HALT: begin
				if (startPress) begin
					next_singleLatched = singleStepSwitch;
					next_manualLatched = manualSourceSwitch;
					if (manualSourceSwitch) begin
						next_instr = dialInstr;
						next_startPulse = 1'b1;
						next_state = ST_EXEC;
					end else begin
						next_state = ST_FETCH;
					end
				end
			end
			ST_FETCH: begin
				next_instr = fetched;
				next_startPulse = 1'b1;
				next_state = ST_EXEC;
			end
			ST_EXEC: begin
				if (execResult.done) begin
					events[IRQ_TRUNC] = execTrunc;
					if (execAlarm) begin
						events[IRQ_ALARM] = 1'b1;
						next_state = ST_ALARM;
					end else if (manualLatched) begin
						events[IRQ_MANUAL] = 1'b1;
						next_state = ST_HALT;
					end else begin
						if (execResult.jump) begin
							next_pos = execResult.target;
						end else begin
							next_pos = pos + 7'h01;
						end
						if (singleLatched) begin
							events[IRQ_STEP] = 1'b1;
							next_state = ST_HALT;
						end else if (singleStepSwitch || manualSourceSwitch) begin
							events[IRQ_STEP] = 1'b1;
							next_state = ST_HALT;
						end else begin
							next_state = ST_FETCH;
						end
					end
				end
			end
			ST_ALARM: begin
				if (clearReq) begin
					next_state = ST_HALT;
				end
			end
			default: begin
				next_state = ST_HALT;
			end
		endcase
		if (next_startPulse) begin
			if (next_instr.op == OP_PRINT && next_instr.unit != UNIT_NOPRINT) begin
				next_printEn = 1'b1;
			end
			if (next_instr.op == OP_PRINT) begin
				next_bar = barHit;
			end else begin
				next_bar = 4'h0;
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_HALT;
			pos <= POS_RESET;
			singleLatched <= 1'b0;
			manualLatched <= 1'b0;
			prevStart <= 1'b0;
			instr <= '0;
			startPulse <= 1'b0;
			printEn <= 1'b0;
			bar <= 4'h0;
		end else begin
			state <= next_state;
			pos <= next_pos;
			singleLatched <= next_singleLatched;
			manualLatched <= next_manualLatched;
			prevStart <= stepStartButton;
			instr <= next_instr;
			startPulse <= next_startPulse;
			printEn <= next_printEn;
			bar <= next_bar;
		end
	end

	// Bus and event next state
	always_comb begin
		next_ack = (avsRead || avsWrite) && !ack;
		next_rdData = rdData;
		next_irqMask = irqMask;
		w1c = 4'h0;
		if (avsRead && !ack) begin
			next_rdData = 32'h0000_0000;
			case (avsAddress)
				REG_STATUS: begin
					next_rdData[STAT_POS_LSB +: POS_W] = pos;
					next_rdData[STAT_HALT_BIT] = (state == ST_HALT) || (state == ST_ALARM);
					next_rdData[STAT_ALARM_BIT] = (state == ST_ALARM);
					next_rdData[STAT_RUN_BIT] = (state == ST_FETCH) || (state == ST_EXEC);
					next_rdData[STAT_SINGLE_BIT] = singleLatched;
					next_rdData[STAT_MANUAL_BIT] = manualLatched;
				end
				REG_IRQ_STAT: begin
					next_rdData[IRQ_W-1:0] = irqStat;
				end
				REG_IRQ_MASK: begin
					next_rdData[IRQ_W-1:0] = irqMask;
				end
				default: begin
					next_rdData = 32'h0000_0000;
				end
			endcase
		end
		if (busWrite && avsByteEnable[0]) begin
			if (avsAddress == REG_IRQ_STAT) begin
				w1c = avsWriteData[IRQ_W-1:0];
			end
			if (avsAddress == REG_IRQ_MASK) begin
				next_irqMask = avsWriteData[IRQ_W-1:0];
			end
		end
		next_irqStat = (irqStat & ~w1c) | events;
	end

	// Bus and event registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ack <= 1'b0;
			rdData <= 32'h0000_0000;
			irqStat <= 4'h0;
			irqMask <= IRQ_MASK_RESET;
		end else begin
			ack <= next_ack;
			rdData <= next_rdData;
			irqStat <= next_irqStat;
			irqMask <= next_irqMask;
		end
	end

	// Lamp and interrupt next state
	always_comb begin
		next_haltShown = (next_state == ST_HALT) || (next_state == ST_ALARM);
		next_alarmShown = (next_state == ST_ALARM);
		next_irqLevel = |(next_irqStat & next_irqMask);
	end

	// Lamp and interrupt registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			haltShown <= 1'b1;
			alarmShown <= 1'b0;
			irqLevel <= 1'b0;
		end else begin
			haltShown <= next_haltShown;
			alarmShown <= next_alarmShown;
			irqLevel <= next_irqLevel;
		end
	end

	// Outputs
	assign avsWaitRequest = (avsRead || avsWrite) && !ack;
	assign avsReadData = rdData;
	assign irq = irqLevel;
	assign haltLamp = haltShown;
	assign alarmLamp = alarmShown;
	assign progPos = pos;
	assign execStart = startPulse;
	assign execInstr = instr;
	assign execManual = manualLatched;
	assign printEnable = printEn;
	assign motorBar = bar;

endmodule // smec_sequencer
`default_nettype wire

/* File: smec_sequencer_chk.sv */
// Port assertions for the execution sequencer
`timescale 1ns/100ps
`default_nettype none
module smec_sequencer_chk
	import smec_pkg::*;
(
	// Clock, reset, bus
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic avsWrite,
	// Panel and lamps
	input wire logic stepStartButton,
	input wire logic clearButton,
	input wire logic singleStepSwitch,
	input wire logic manualSourceSwitch,
	input wire logic haltLamp,
	input wire logic alarmLamp,
	input wire logic [6:0] progPos,
	// Execution and printer
	input wire logic execStart,
	input wire smec_instr_t execInstr,
	input wire logic execManual,
	input wire smec_result_t execResult,
	input wire logic [3:0] motorBar
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// Press taken in halt
	sequence s_press;
		!stepStartButton ##1 stepStartButton && haltLamp && !alarmLamp;
	endsequence
	// Finished instruction of one kind
	sequence s_done(logic [3:0] opc);
		execResult.done && execInstr.op == opc;
	endsequence
	a_manual_issue: assert property (
		s_press ##0 manualSourceSwitch |=> execStart && execManual)
		else $error("manual issue missing");
	a_stored_issue: assert property (
		s_press ##0 !manualSourceSwitch |=> !execStart ##1 execStart && !execManual)
		else $error("stored issue missing");
	a_run_on: assert property (
		execResult.done && !execManual && !singleStepSwitch && !manualSourceSwitch
		&& execResult.leadDigit == 4'h0 |=> !haltLamp ##1 execStart)
		else $error("run paused");
	a_manual_pos: assert property (
		execStart && execManual |=> $stable(progPos) [*3])
		else $error("manual moved position");
	a_print_bar: assert property (
		execStart && execInstr.op == OP_PRINT && execInstr.addr inside {[1:4]}
		|-> motorBar == 4'h1 << (execInstr.addr - 4'h1))
		else $error("wrong motor bar");
	a_mul_quiet: assert property (
		s_done(OP_MUL) |=> !alarmLamp)
		else $error("multiply alarmed");
	a_div_alarm: assert property (
		s_done(OP_DIV) ##0 execResult.leadDigit != 4'h0
		|=> alarmLamp && haltLamp && $stable(progPos))
		else $error("divide overflow missed");
	a_alarm_hold: assert property (
		alarmLamp && !clearButton && !avsWrite |=> alarmLamp && !execStart)
		else $error("alarm not held");
endmodule // smec_sequencer_chk
`default_nettype wire

/* File: tb_step_and_manual_exec_control.sv */
// Self-checking bench for the execution sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_step_and_manual_exec_control;
	import smec_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [3:0] avsAddress = 4'h0;
	logic [31:0] avsWriteData = 32'h0;
	logic [31:0] avsReadData;
	logic avsWaitRequest, irq, haltLamp, alarmLamp, execStart, execManual, printEnable;
	logic stepStartButton, clearButton, singleStepSwitch, manualSourceSwitch;
	logic [6:0] progPos;
	logic [3:0] motorBar;
	logic [3:0] resLead = 4'h0;
	logic resLow = 1'b0;
	logic resJmp = 1'b0;
	logic [1:0] sh = 2'h0;
	smec_instr_t dials, execInstr, ins;
	smec_instr_t prog [0:127];
	smec_result_t execResult = '0;
	logic [63:0] rdQ [$];
	logic [63:0] rdNote;
	logic [17:0] isQ [$];
	int errors = 0;
	int checked = 0;
	always #5 core_clk = ~core_clk;
	smec_sequencer dut (.core_clk, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
		.avsByteEnable(4'hF), .avsReadData, .avsWaitRequest, .irq, .stepStartButton,
		.clearButton, .singleStepSwitch, .manualSourceSwitch, .dialOp(dials.op),
		.dialAddr(dials.addr), .dialUnit(dials.unit), .haltLamp, .alarmLamp, .progPos,
		.progInstr(prog[progPos]), .execStart, .execInstr, .execManual, .execResult,
		.printEnable, .motorBar);
	smec_panel panel (.core_clk, .haltLamp, .stepStartButton, .clearButton,
		.singleStepSwitch, .manualSourceSwitch, .dials);
	// Execution unit answers three cycles after issue
	always @(posedge core_clk) begin
		sh <= {sh[0], execStart === 1'b1};
		execResult <= '{sh[1], resJmp, 7'h2A, resLead, resLow};
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Compare each result with the oldest note
	always @(posedge core_clk) begin
		if (avsRead && avsWaitRequest === 1'b0)
			if (rdQ.size() == 0) check("spare read", 32'h0, 32'h1);
			else begin
				rdNote = rdQ.pop_front();
				check("readdata", rdNote[31:0], avsReadData & rdNote[63:32]);
			end
		if (execStart === 1'b1)
			if (isQ.size() == 0) check("spare issue", 32'h0, 32'h1);
			else check("issue", 32'(isQ.pop_front()),
				32'({execManual, execInstr, printEnable, motorBar}));
	end
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avsWrite <= wr;
		avsRead <= !wr;
		avsAddress <= a;
		avsWriteData <= d;
		@(posedge core_clk);
		while (avsWaitRequest !== 1'b0) @(posedge core_clk);
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [63:0] e);
		rdQ.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	function automatic logic [17:0] note(input smec_instr_t i, input logic m);
		smec_instr_t o;
		o = i;
		if (i.op == OP_STORE) o[7:0] = 8'h00;
		if (i.op == OP_SHIFT) o.unit = 4'h0;
		return {m, o, i.op == OP_PRINT && i.unit != UNIT_NOPRINT,
			i.op == OP_PRINT && i.addr inside {[1:4]} ? 4'h1 << (i.addr - 4'h1) : 4'h0};
	endfunction
	task automatic step(input smec_instr_t i, input logic m);
		isQ.push_back(note(i, m));
		panel.hit(1'b0);
		repeat (2) @(posedge core_clk);
		for (int n = 0; n < 40 && haltLamp !== 1'b1; n++) @(posedge core_clk);
		check("halt lamp", 32'h1, 32'(haltLamp));
	endtask
	task automatic close_out();
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(16));
		for (int i = 0; i < 128; i++) prog[i] = '{OP_ADD, 4'(i), 4'h1};
		prog[3].op = OP_MUL;
		prog[4].op = OP_DIV;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(4'h0, {32'h37F, 32'h100});
		rd(4'h2, {32'hFFFFFFFF, 32'h0});
		bus(1'b1, 4'h8, 32'h6);
		panel.setSw(1'b1, 1'b0);
		step(prog[0], 1'b0);
		step(prog[1], 1'b0);
		check("irq", 32'h1, 32'(irq));
		bus(1'b1, 4'h4, 32'hF);
		@(posedge core_clk);
		check("irq", 32'h0, 32'(irq));
		panel.setSw(1'b1, 1'b1);
		for (int k = 0; k < 28; k++) begin
			ins = '{4'(k % 7 + 1), 4'(k % 4 + 1), k == 6 ? 4'h0 : 4'($urandom_range(15, 1))};
			panel.setDials(ins);
			step(ins, 1'b1);
		end
		rd(4'h0, {32'h37F, 32'h102});
		panel.setSw(1'b1, 1'b0);
		step(prog[2], 1'b0);
		resLow <= 1'b1;
		step(prog[3], 1'b0);
		rd(4'h4, {32'h9, 32'h8});
		resLow <= 1'b0;
		resLead <= 4'h2;
		step(prog[4], 1'b0);
		rd(4'h0, {32'h37F, 32'h304});
		panel.hit(1'b0);
		rd(4'h0, {32'h37F, 32'h304});
		resLead <= 4'h0;
		panel.hit(1'b1);
		rd(4'h0, {32'h37F, 32'h104});
		for (int k = 4; k < 8; k++) isQ.push_back(note(prog[k], 1'b0));
		panel.setSw(1'b0, 1'b0);
		panel.hit(1'b0);
		for (int n = 0; n < 200 && isQ.size() > 0; n++) @(posedge core_clk);
		panel.setSw(1'b1, 1'b0);
		for (int n = 0; n < 40 && haltLamp !== 1'b1; n++) @(posedge core_clk);
		check("halt lamp", 32'h1, 32'(haltLamp));
		rd(4'h0, {32'h37F, 32'h108});
		resJmp <= 1'b1;
		step(prog[8], 1'b0);
		rd(4'h0, {32'h37F, 32'h12A});
		check("notes left", 32'h0, 32'(isQ.size()));
		close_out();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		close_out();
	end
endmodule // tb_step_and_manual_exec_control
bind smec_sequencer smec_sequencer_chk chk (.core_clk, .rst_n, .avsWrite, .stepStartButton,
	.clearButton, .singleStepSwitch, .manualSourceSwitch, .haltLamp, .alarmLamp, .progPos,
	.execStart, .execInstr, .execManual, .execResult, .motorBar);
`default_nettype wire
